// *** inc/fbs_pkg.sv ***
/*
 * Constants, command codes, step timing and types for the host-side flash
 * command sequencer.
 * Assumes a 25 MHz system clock and a byte-wide parallel NOR flash on the pins.
 */
`default_nettype none

package fbs_pkg;

    // =========================================================================
    // Bus widths and fixed command values
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;

    localparam logic [7:0] CMD_BYPASS_ENTER  = 8'h20;
    localparam logic [7:0] CMD_BYPASS_PROG   = 8'ha0;
    localparam logic [7:0] CMD_BYPASS_EXIT_A = 8'h90;
    localparam logic [7:0] CMD_BYPASS_EXIT_B = 8'h00;
    localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h30;

    // Defaults for the values that stay open until build time.
    localparam logic [ADDR_W-1:0] DEF_UNLOCK_ADDR_A = 20'h00aa0;
    localparam logic [ADDR_W-1:0] DEF_UNLOCK_ADDR_B = 20'h00550;
    localparam logic [7:0]        DEF_UNLOCK_DATA_A = 8'hc3;
    localparam logic [7:0]        DEF_UNLOCK_DATA_B = 8'h3c;
    localparam logic [7:0]        DEF_ERASE_SETUP   = 8'h81;
    localparam logic [7:0]        DEF_CHIP_ERASE    = 8'h11;
    localparam logic [7:0]        DEF_RESET_CMD     = 8'hf1;

    // Status bit positions on the data pins.
    localparam int DONE_POLL_BIT  = 7;
    localparam int TIME_LIMIT_BIT = 5;

    // =========================================================================
    // Timing
    localparam int CLK_NS        = 40;
    localparam int T_WE_LOW_NS   = 35;
    localparam int T_WE_HIGH_NS  = 30;
    localparam int T_ACCESS_NS   = 70;
    localparam int T_WINDOW_NS   = 40000;
    localparam int SYNC_LAT      = 4;
    localparam int CNT_W         = 16;
    localparam int WE_LOW_CYC    = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_HIGH_CYC   = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_HOLD_CYC   = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
    localparam int WINDOW_CYC    = T_WINDOW_NS / CLK_NS;

    // =========================================================================
    // Types
    typedef enum logic [2:0] {
        OP_BYP_ENTER = 3'h0,
        OP_BYP_PROG  = 3'h1,
        OP_BYP_EXIT  = 3'h2,
        OP_CHIP      = 3'h3,
        OP_SECT      = 3'h4,
        OP_SECT_ADD  = 3'h5,
        OP_RESET     = 3'h6
    } fbs_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_WSET  = 3'h1,
        ST_WLOW  = 3'h3,
        ST_WHIGH = 3'h2,
        ST_WIN   = 3'h6,
        ST_RLOW  = 3'h7,
        ST_REVAL = 3'h5
    } fbs_state_t;

endpackage

`default_nettype wire

// *** design/fbs_pin_sync.sv ***
/*
 * Three-stage synchroniser for pins that arrive from outside the clock domain.
 * Assumes the pin is quasi-static for a few cycles; a change is passed on only
 * once the second and third stages agree.
 */
`default_nettype none

module fbs_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pinIn,
    output var  logic [W-1:0] syncOut
);

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage3_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            syncOut    <= '0;
        end
        else
        begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            for (int i = 0; i < W; i++)
            begin
                if (stage2_reg[i] == stage3_reg[i])
                begin
                    syncOut[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** design/fbs_host.sv ***
/*
 * Host-side command sequencer for a parallel NOR flash: unlock bypass entry,
 * bypass program and exit, chip erase and multi-sector erase with polling.
 * Assumes the flash pins are wired directly, the data bus resolved outside
 * from flashDoutEnN, and a user that waits for cmdReady before each order.
 */
`default_nettype none

module fbs_host
    import fbs_pkg::*;
#(
    parameter logic [ADDR_W-1:0] UNLOCK_ADDR_A = DEF_UNLOCK_ADDR_A,
    parameter logic [ADDR_W-1:0] UNLOCK_ADDR_B = DEF_UNLOCK_ADDR_B,
    parameter logic [7:0]        UNLOCK_DATA_A = DEF_UNLOCK_DATA_A,
    parameter logic [7:0]        UNLOCK_DATA_B = DEF_UNLOCK_DATA_B,
    parameter logic [7:0]        ERASE_SETUP   = DEF_ERASE_SETUP,
    parameter logic [7:0]        CHIP_ERASE    = DEF_CHIP_ERASE,
    parameter logic [7:0]        RESET_CMD     = DEF_RESET_CMD
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              cmdValid,
    input  wire logic [2:0]        cmdOp,
    input  wire logic [ADDR_W-1:0] cmdAddr,
    input  wire logic [DATA_W-1:0] cmdData,
    output var  logic              cmdReady,
    output var  logic              cmdReject,
    output var  logic              opDone,
    output var  logic              opFail,
    output var  logic              inBypass,
    output var  logic              flashReady,
    output var  logic [ADDR_W-1:0] flashAddr,
    output var  logic [DATA_W-1:0] flashDout,
    output var  logic              flashDoutEnN,
    input  wire logic [DATA_W-1:0] flashDin,
    output var  logic              flashCeN,
    output var  logic              flashWeN,
    output var  logic              flashOeN,
    input  wire logic              readyBusyIn
);

    // =========================================================================
    // Pin synchronisers
    logic [DATA_W-1:0] dqSync;
    logic              rbSync;
    fbs_pin_sync #(.W(DATA_W)) uDqSync (
        .clk     (clk),
        .nrst    (nrst),
        .pinIn   (flashDin),
        .syncOut (dqSync)
    );
    fbs_pin_sync #(.W(1)) uRbSync (
        .clk     (clk),
        .nrst    (nrst),
        .pinIn   (readyBusyIn),
        .syncOut (rbSync)
    );

    // =========================================================================
    // Sequencer state
    fbs_state_t        state_reg;
    fbs_state_t        state_next;
    fbs_op_t           op_reg;
    logic [2:0]        step_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] data_reg;
    logic [ADDR_W-1:0] stepAddr;
    logic [7:0]        stepData;
    logic              lastStep;
    logic              legal;
    logic              accept;
    logic              refuse;
    logic              pollMatch;
    logic              pollFail;
    logic              writesDone;
    fbs_state_t        afterWrites;

    // =========================================================================
    // Command legality
    // Anything but another sector would abort the queued erase.
    assign legal = (state_reg == ST_WIN) ? (cmdOp == OP_SECT_ADD)
                 : inBypass ? ((cmdOp == OP_BYP_PROG) || (cmdOp == OP_BYP_EXIT))
                 : ((cmdOp == OP_BYP_ENTER) || (cmdOp == OP_CHIP)
                    || (cmdOp == OP_SECT) || (cmdOp == OP_RESET));

    assign accept = cmdValid && cmdReady && legal;
    assign refuse = cmdValid && cmdReady && !legal;

    // =========================================================================
    // Write step table: address and data of each bus write per operation
    always_comb
    begin
        stepAddr = UNLOCK_ADDR_A;
        stepData = UNLOCK_DATA_A;
        lastStep = 1'b0;
        case (op_reg)
            OP_BYP_PROG:
            begin
                if (step_reg == 3'h0)
                    stepData = CMD_BYPASS_PROG;
                else
                begin
                    stepAddr = addr_reg;
                    stepData = data_reg;
                    lastStep = 1'b1;
                end
            end
            OP_BYP_EXIT:
            begin
                stepAddr = addr_reg;
                stepData = (step_reg == 3'h0) ? CMD_BYPASS_EXIT_A : CMD_BYPASS_EXIT_B;
                lastStep = (step_reg != 3'h0);
            end
            OP_SECT_ADD, OP_RESET:
            begin
                stepAddr = addr_reg;
                stepData = (op_reg == OP_RESET) ? RESET_CMD : CMD_SECTOR_ERASE;
                lastStep = 1'b1;
            end
            default:
            begin
                // Unlock pair, command, then for erases a second unlock pair.
                if (step_reg == 3'h1 || step_reg == 3'h4)
                begin
                    stepAddr = UNLOCK_ADDR_B;
                    stepData = UNLOCK_DATA_B;
                end
                else if (step_reg == 3'h2)
                begin
                    stepData = (op_reg == OP_BYP_ENTER) ? CMD_BYPASS_ENTER : ERASE_SETUP;
                    lastStep = (op_reg == OP_BYP_ENTER);
                end
                else if (step_reg == 3'h5)
                begin
                    if (op_reg == OP_SECT)
                    begin
                        stepAddr = addr_reg;
                        stepData = CMD_SECTOR_ERASE;
                    end
                    else
                        stepData = CHIP_ERASE;
                    lastStep = 1'b1;
                end
            end
        endcase
    end

    // =========================================================================
    // Next state
    assign pollMatch  = dqSync[DONE_POLL_BIT] == ((op_reg == OP_BYP_PROG) ? data_reg[7] : 1'b1);
    assign pollFail   = dqSync[TIME_LIMIT_BIT];
    assign writesDone = (state_reg == ST_WHIGH) && (cnt_reg == '0) && lastStep;

    assign afterWrites = (op_reg == OP_SECT || op_reg == OP_SECT_ADD) ? ST_WIN
                       : (op_reg == OP_CHIP || op_reg == OP_BYP_PROG) ? ST_RLOW : ST_IDLE;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (accept)
                    state_next = ST_WSET;
            ST_WSET:
                state_next = ST_WLOW;
            ST_WLOW:
                if (cnt_reg == '0)
                    state_next = ST_WHIGH;
            ST_WHIGH:
                if (cnt_reg == '0)
                    state_next = lastStep ? afterWrites : ST_WSET;
            ST_WIN:
                if (accept)
                    state_next = ST_WSET;
                else if (cnt_reg == '0)
                    state_next = ST_RLOW;
            ST_RLOW:
                if (cnt_reg == '0)
                    state_next = ST_REVAL;
            ST_REVAL:
                if (pollMatch)
                    state_next = ST_IDLE;
                else if (pollFail)
                    state_next = ST_WSET;
                else
                    state_next = ST_RLOW;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // =========================================================================
    // Sequencer registers and pins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg    <= ST_IDLE;
            op_reg       <= OP_RESET;
            step_reg     <= 3'h0;
            cnt_reg      <= '0;
            addr_reg     <= '0;
            data_reg     <= '0;
            flashAddr    <= '0;
            flashDout    <= '0;
            flashDoutEnN <= 1'b1;
            flashCeN     <= 1'b1;
            flashWeN     <= 1'b1;
            flashOeN     <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            if (accept)
            begin
                op_reg   <= fbs_op_t'(cmdOp);
                step_reg <= 3'h0;
                addr_reg <= cmdAddr;
                data_reg <= cmdData;
            end
            else if (state_reg == ST_REVAL && !pollMatch && pollFail)
            begin
                op_reg   <= OP_RESET;
                step_reg <= 3'h0;
            end
            else if (state_reg == ST_WHIGH && cnt_reg == '0 && !lastStep)
                step_reg <= step_reg + 3'h1;
            // Timers load on state entry; entering the window again after
            // each added sector restarts the time-out.
            if (state_next != state_reg || (state_reg == ST_REVAL))
            begin
                case (state_next)
                    ST_WLOW:  cnt_reg <= CNT_W'(WE_LOW_CYC - 1);
                    ST_WHIGH: cnt_reg <= CNT_W'(WE_HIGH_CYC - 1);
                    ST_RLOW:  cnt_reg <= CNT_W'(RD_HOLD_CYC - 1);
                    ST_WIN:   cnt_reg <= CNT_W'(WINDOW_CYC - 1);
                    default:  cnt_reg <= '0;
                endcase
            end
            else if (cnt_reg != '0)
                cnt_reg <= cnt_reg - CNT_W'(1);
            if (state_reg == ST_WSET)
            begin
                flashAddr <= stepAddr;
                flashDout <= stepData;
            end
            else if (state_next == ST_RLOW && state_reg != ST_RLOW)
                flashAddr <= addr_reg;
            flashDoutEnN <= !(state_next == ST_WSET || state_next == ST_WLOW
                              || state_next == ST_WHIGH);
            flashCeN     <= !(state_next == ST_WSET || state_next == ST_WLOW
                              || state_next == ST_WHIGH || state_next == ST_RLOW);
            flashWeN     <= !(state_next == ST_WLOW);
            flashOeN     <= !(state_next == ST_RLOW);
        end
    end

    // =========================================================================
    // User-side status
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmdReady   <= 1'b0;
            cmdReject  <= 1'b0;
            opDone     <= 1'b0;
            opFail     <= 1'b0;
            inBypass   <= 1'b0;
            flashReady <= 1'b0;
        end
        else
        begin
            flashReady <= rbSync;
            // The device refuses new orders while its algorithm runs.
            cmdReady   <= (state_next == ST_IDLE && rbSync) || state_next == ST_WIN;
            cmdReject  <= refuse;
            opDone     <= (state_reg == ST_REVAL && pollMatch)
                       || (writesDone && afterWrites == ST_IDLE);
            if (accept)
                opFail <= 1'b0;
            else if (state_reg == ST_REVAL && !pollMatch && pollFail)
                opFail <= 1'b1;
            if (writesDone && op_reg == OP_BYP_ENTER)
                inBypass <= 1'b1;
            else if (writesDone && (op_reg == OP_BYP_EXIT || op_reg == OP_RESET))
                inBypass <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** sim/fbs_host_monitor.sv ***
/*
 * Concurrent checks on the ports of the host flash command sequencer.
 * Assumes the design is built with the package's default command values.
 */
`default_nettype none

module fbs_host_monitor
    import fbs_pkg::*;
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              cmdValid,
    input wire logic              cmdReady,
    input wire logic              cmdReject,
    input wire logic              opDone,
    input wire logic              opFail,
    input wire logic              inBypass,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic [DATA_W-1:0] flashDout,
    input wire logic              flashDoutEnN,
    input wire logic              flashCeN,
    input wire logic              flashWeN,
    input wire logic              flashOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================================
    // Pin-level write and read cycles
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // A write is identified by the strobe fall, where the flash takes the address.
    sequence s_wr(logic [7:0] v);
        $fell(flashWeN) && flashDout == v;
    endsequence

    AST_WE_QUAL: assert property (!flashWeN |-> !flashCeN && !flashDoutEnN && flashOeN)
        else $error("write strobe low without select and data drive");
    AST_WE_ONE: assert property ($fell(flashWeN) |=> flashWeN)
        else $error("write strobe low for more than one cycle");
    AST_HOLD: assert property ($rose(flashWeN) |-> $stable(flashAddr) && $stable(flashDout))
        else $error("address or data moved across the strobe rise");
    AST_READ_BUS: assert property (!flashOeN |-> flashDoutEnN && flashWeN)
        else $error("host drives the bus during a poll read");

    // =========================================================================
    // User order port
    AST_ACCEPT: assert property (cmdValid && cmdReady |-> ##[1:2] (!cmdReady || cmdReject))
        else $error("order neither taken nor refused");
    AST_REJ_QUIET: assert property (cmdReject |-> flashWeN && flashDoutEnN)
        else $error("refused order reached the pins");
    AST_DONE_PULSE: assert property (opDone |=> !opDone)
        else $error("completion pulse longer than one cycle");

    // =========================================================================
    // Command sequences
    AST_BYP_ENTER: assert property (s_wr(CMD_BYPASS_ENTER) |-> ##[1:6] inBypass)
        else $error("bypass flag not set after entry command");
    AST_BYP_EXIT: assert property (s_wr(CMD_BYPASS_EXIT_A) ##[3:8] s_wr(CMD_BYPASS_EXIT_B)
        |-> ##[1:6] !inBypass)
        else $error("bypass flag not cleared after exit pair");
    AST_SECT_WAIT: assert property (s_wr(CMD_SECTOR_ERASE) ##0 !inBypass |=> flashOeN [*8])
        else $error("poll read started inside the sector window");
    AST_FAIL_EXIT: assert property ($rose(opFail) |-> ##[0:12] s_wr(DEF_RESET_CMD)
        ##[1:8] opDone)
        else $error("time-limit failure not closed by a reset write");
endmodule

bind fbs_host fbs_host_monitor mon_u (
    .clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdReject(cmdReject), .opDone(opDone), .opFail(opFail), .inBypass(inBypass),
    .flashAddr(flashAddr), .flashDout(flashDout), .flashDoutEnN(flashDoutEnN),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN)
);

`default_nettype wire

// *** sim/fbs_flash_model.sv ***
/*
 * Behavioural model of the parallel flash command interpreter.
 * Assumes clk only stands in for the device's internal timer.
 */
`default_nettype none

module fbs_flash_model
    import fbs_pkg::*;
#(
    parameter int TOUT_CYC  = 1200,
    parameter int ERASE_CYC = 300,
    parameter int PROG_CYC  = 20
) (
    input  wire logic              clk,
    input  wire logic              ceN,
    input  wire logic              weN,
    input  wire logic              oeN,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dIn,
    input  wire logic              failMode,
    output var  logic [DATA_W-1:0] dOut,
    output var  logic              ryBy
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RD = 0, BYP = 1, BPRG = 2, BEX = 3, WIN = 4, BUSY = 5;
    logic [7:0]        mem [int];
    logic [15:0]       selSect = '0;
    logic [ADDR_W-1:0] la = '0;
    logic [7:0]        pd = '0, rdVal = '0, lastOut = '0;
    logic              tgl = 1'b0, failed = 1'b0, isErase = 1'b0;
    int                mode = RD, retMode = RD, step = 0, tmr = 0, busyCnt = 0;
    int                nWrites = 0, nSect = 0;

    task automatic start(input int cyc, input logic er);
        busyCnt = cyc;
        isErase = er;
        retMode = er ? RD : BYP;
        mode = BUSY;
    endtask

    // =========================================================================
    // Command decoding
    task automatic seq_step(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int nxt;
        nxt = 0;
        if ((step == 0 || step == 3) && a == DEF_UNLOCK_ADDR_A && d == DEF_UNLOCK_DATA_A)
            nxt = step + 1;
        else if ((step == 1 || step == 4) && a == DEF_UNLOCK_ADDR_B && d == DEF_UNLOCK_DATA_B)
            nxt = step + 1;
        else if (step == 2 && d == DEF_ERASE_SETUP)
            nxt = 3;
        else if (step == 2 && d == CMD_BYPASS_ENTER)
            mode = BYP;
        else if (step == 5 && d == DEF_CHIP_ERASE)
        begin
            selSect = '1;
            start(ERASE_CYC, 1'b1);
        end
        else if (step == 5 && d == CMD_SECTOR_ERASE)
        begin
            selSect = '0;
            selSect[a[19:16]] = 1'b1;
            nSect = 1;
            isErase = 1'b1;
            tmr = 0;
            mode = WIN;
        end
        step = nxt;
    endtask

    always @(negedge weN)
        if (!ceN)
        begin
            la = addr;
            tmr = 0;
        end

    always @(posedge weN)
        if (!ceN)
        begin
            nWrites++;
            if (failed && dIn == DEF_RESET_CMD)
            begin
                failed = 1'b0;
                mode = RD;
            end
            else if (!failed)
                case (mode)
                    BYP: mode = (dIn == CMD_BYPASS_PROG) ? BPRG :
                                (dIn == CMD_BYPASS_EXIT_A) ? BEX : BYP;
                    BPRG:
                    begin
                        mem[int'(la)] = dIn;
                        pd = dIn;
                        start(PROG_CYC, 1'b0);
                    end
                    BEX: mode = (dIn == CMD_BYPASS_EXIT_B) ? RD : BYP;
                    WIN:
                    begin
                        if (dIn == CMD_SECTOR_ERASE)
                            nSect++;
                        if (dIn == CMD_SECTOR_ERASE)
                            selSect[la[19:16]] = 1'b1;
                        else
                            mode = RD;
                    end
                    RD: seq_step(la, dIn);
                    default: ;
                endcase
        end

    // =========================================================================
    // Algorithm timing and status reads
    task automatic finish_op;
        int keys[$];
        if (failMode)
            failed = 1'b1;
        else
        begin
            if (isErase)
                foreach (mem[k])
                    if (selSect[k[19:16]])
                        keys.push_back(k);
            foreach (keys[i])
                mem.delete(keys[i]);
            mode = retMode;
        end
    endtask

    always @(negedge oeN)
        tgl = ~tgl;

    always @(posedge clk)
    begin
        if (mode == BUSY || mode == WIN)
            rdVal <= {isErase ? 1'b0 : ~pd[7], tgl, failed, 5'h00};
        else
            rdVal <= mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff;
        if (!ceN && !oeN)
            lastOut <= dOut;
        if (mode == WIN && ++tmr >= TOUT_CYC)
            start(ERASE_CYC, 1'b1);
        else if (mode == BUSY && !failed && --busyCnt == 0)
            finish_op();
    end

    // A released bus shows the inverse of the last value so a stale read cannot pass.
    assign dOut = (!ceN && !oeN) ? rdVal : ~lastOut;
    assign ryBy = !(mode == BUSY && !failed);
endmodule

`default_nettype wire

// *** sim/fbs_host_tb.sv ***
/*
 * Self-checking bench: user orders to the host sequencer, flash model behind it.
 * Assumes the design's default unlock and command parameters.
 */
`default_nettype none

module fbs_host_tb import fbs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, nrst, cmdValid, cmdReady, cmdReject, opDone, opFail, inBypass;
    logic              flashReady, flashDoutEnN, flashCeN, flashWeN, flashOeN, ryBy;
    logic              failMode, rej, sawBusy;
    logic [2:0]        cmdOp;
    logic [ADDR_W-1:0] cmdAddr, flashAddr;
    logic [DATA_W-1:0] cmdData, flashDout, mdlOut, bus;
    int                n_errors = 0, check_count = 0;

    assign bus = flashDoutEnN ? mdlOut : flashDout;

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    fbs_host dut_u (.clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .cmdReject(cmdReject),
        .opDone(opDone), .opFail(opFail), .inBypass(inBypass), .flashReady(flashReady),
        .flashAddr(flashAddr), .flashDout(flashDout), .flashDoutEnN(flashDoutEnN),
        .flashDin(bus), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
        .readyBusyIn(ryBy));

    fbs_flash_model mdl_u (.clk(clk), .ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN),
        .addr(flashAddr), .dIn(bus), .failMode(failMode), .dOut(mdlOut), .ryBy(ryBy));

    // =========================================================================
    // Bench tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t ns: seen %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Waits for cmdReady (which = 0) or the completion pulse (which = 1).
    task automatic wait_for(input int which);
        int i;
        i = 0;
        sawBusy = 1'b0;
        while ((which ? opDone : cmdReady) !== 1'b1)
        begin
            if (flashReady === 1'b0)
                sawBusy = 1'b1;
            @(negedge clk);
            i++;
            if (i > 20000)
            begin
                n_errors++;
                end_sim();
            end
        end
    endtask

    task automatic issue(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d);
        wait_for(0);
        cmdOp = op;
        cmdAddr = a;
        cmdData = d;
        cmdValid = 1'b1;
        @(negedge clk);
        cmdValid = 1'b0;
        rej = cmdReject;
        @(negedge clk);
    endtask

    task automatic run(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d,
                       input logic expRej);
        issue(op, a, d);
        check(rej, expRej);
        if (!expRej)
            wait_for(1);
    endtask

    // =========================================================================
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        cmdValid = 1'b0;
        cmdOp = 3'h0;
        cmdAddr = 20'h00000;
        cmdData = 8'h00;
        failMode = 1'b0;
        repeat (2) @(negedge clk);
        check(flashWeN, 1'b1);
        check(cmdReady, 1'b0);
        nrst = 1'b1;
        run(3'h1, 20'h00000, 8'h00, 1'b1);
        run(3'h5, 20'h00000, 8'h00, 1'b1);
        check(mdl_u.nWrites, 0);
        run(3'h0, 20'h00000, 8'h00, 1'b0);
        check(inBypass, 1'b1);
        check(mdl_u.mode, 1);
        run(3'h3, 20'h00000, 8'h00, 1'b1);
        for (int i = 0; i < 3; i++)
            run(3'h1, {4'(i + 1), 16'h0012}, 8'h5a ^ 8'(i), 1'b0);
        check(mdl_u.nWrites, 9);
        check(mdl_u.mem[20'h20012], 8'h5b);
        run(3'h2, 20'h00000, 8'h00, 1'b0);
        check(inBypass, 1'b0);
        check(mdl_u.mode, 0);
        issue(3'h4, 20'h10040, 8'h00);
        check(rej, 1'b0);
        issue(3'h5, 20'h20000, 8'h00);
        check(rej, 1'b0);
        issue(3'h0, 20'h00000, 8'h00);
        check(rej, 1'b1);
        wait_for(1);
        check(sawBusy, 1'b1);
        check(mdl_u.nSect, 2);
        check(mdl_u.mem.exists(20'h10012), 0);
        check(mdl_u.mem[20'h30012], 8'h58);
        check(opFail, 1'b0);
        run(3'h3, 20'h00000, 8'h00, 1'b0);
        check(mdl_u.mem.size(), 0);
        check(mdl_u.mode, 0);
        run(3'h6, 20'h00000, 8'h00, 1'b0);
        failMode = 1'b1;
        run(3'h3, 20'h00000, 8'h00, 1'b0);
        check(opFail, 1'b1);
        check(mdl_u.mode, 0);
        end_sim();
    end
endmodule

`default_nettype wire
